//--- vfr_cfg.svh
// Constants of the output and input voltage format register bank.
// Assumes command codes arrive as 16 bits from the PMBus command engine.
`ifndef VFR_CFG_SVH
`define VFR_CFG_SVH

// ------------------------------------------------------------
// Command codes
// ------------------------------------------------------------
`define VFR_CMD_CAPABILITY 16'h0019
`define VFR_CMD_OUT_FORMAT 16'h0020
`define VFR_CMD_OUT_SETPOINT 16'h0021
`define VFR_CMD_LOOP_SCALE 16'h0029
`define VFR_CMD_MON_SCALE 16'h002a
`define VFR_CMD_VIN_START 16'h0035
`define VFR_CMD_VIN_STOP 16'h0036
`define VFR_CMD_VIN_EXP 16'hfe39

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define VFR_F_FMT_MODE 7:5
`define VFR_F_FMT_EXP 2:0
`define VFR_F_SET_MANT 11:0
`define VFR_F_SCL_EXP 13:11
`define VFR_F_SCL_MANT 9:0
`define VFR_F_VIN_EXP 15:11
`define VFR_F_VIN_MANT 10:0
`define VFR_F_VINEXP_SRC 5:3
`define VFR_F_CAP_BYTE 7:0

// ------------------------------------------------------------
// Fixed read values and reset values
// ------------------------------------------------------------
`define VFR_MODE_LINEAR 3'h0
`define VFR_CAP_VALUE 8'h20
`define VFR_RST_EXP3 3'h0
`define VFR_RST_SET_MANT 12'h000
`define VFR_RST_SCL_MANT 10'h000
`define VFR_RST_VIN_MANT 11'h000
`define VFR_ZERO16 16'h0000

`endif

//--- vfr_pkg.sv
// Types shared by the voltage format register bank.
// Assumes vfr_cfg.svh holds the numeric constants.
package vfr_pkg;

  // Exponent and mantissa of the output setpoint
  typedef struct packed {
    logic [2:0] exp;
    logic [11:0] mant;
  } vfr_setpoint_t;

  // Exponent and mantissa of a scale factor
  typedef struct packed {
    logic [2:0] exp;
    logic [9:0] mant;
  } vfr_scale_t;

  typedef enum logic [0:0] {
    VFR_HALT = 1'b0,
    VFR_RUN = 1'b1
  } vfr_conv_t;

endpackage : vfr_pkg

//--- vfr_voltage_format_regs.sv
// Voltage format register bank behind the PMBus command engine.
// Assumes a command engine on CLK delivers one-cycle read/write strobes with a 16-bit
// command code; VIN_MEAS is an in-domain linear mantissa sharing the input exponent.
// Functional notes
// - Capability bit 4 always reads 0; no alert pin or alert protocol.
// - Output format mode bits [7:5] are read-only, fixed to linear.
// - Output format bits [2:0] hold a writable signed output-voltage exponent.
// - Output setpoint bits [15:12] are read-only and read 0000.
// - Output setpoint bits [11:0] hold a writable mantissa using the output exponent.
// - Writing the setpoint sets the regulation target voltage.
// - Loop scale bits [13:11] hold a writable signed exponent for K.
// - Loop scale bits [9:0] hold a writable mantissa; bit 10 reads zero.
// - Monitor scale: [15:14] read-only, [13:11] exponent, bit 10 zero, [9:0] mantissa.
// - Start threshold [15:11] mirrors the input exponent from 0xFE39 bits [5:3].
// - Start threshold holds a writable 11-bit mantissa in [10:8] and [7:0].
// - Conversion starts only when measured input voltage reaches the start threshold.
// - Conversion stops when measured input voltage falls to the stop threshold.
// - Stop threshold has the same layout as the start threshold.
`include "vfr_cfg.svh"

module vfr_voltage_format_regs
  import vfr_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [15:0] CMD,
  input wire logic WR_STB,
  input wire logic [15:0] WR_DATA,
  input wire logic RD_STB,
  output logic [15:0] RD_DATA,
  output logic RD_ACK,
  output logic CMD_ERR,
  input wire logic [10:0] VIN_MEAS,
  output vfr_setpoint_t VOUT_TARGET,
  output vfr_scale_t LOOP_SCALE,
  output vfr_scale_t MONITOR_SCALE_VALUE,
  output logic [2:0] VIN_EXP,
  output logic CONVERT_EN
);

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  wire hit_cap = (CMD == `VFR_CMD_CAPABILITY);
  wire hit_fmt = (CMD == `VFR_CMD_OUT_FORMAT);
  wire hit_set = (CMD == `VFR_CMD_OUT_SETPOINT);
  wire hit_loop = (CMD == `VFR_CMD_LOOP_SCALE);
  wire hit_mon = (CMD == `VFR_CMD_MON_SCALE);
  wire hit_on = (CMD == `VFR_CMD_VIN_START);
  wire hit_off = (CMD == `VFR_CMD_VIN_STOP);
  wire hit_vexp = (CMD == `VFR_CMD_VIN_EXP);
  wire hit_any = hit_cap | hit_fmt | hit_set | hit_loop | hit_mon | hit_on | hit_off | hit_vexp;

  // Capability is read-only, so a write to it counts as refused
  wire wr_fmt = WR_STB & hit_fmt;
  wire wr_set = WR_STB & hit_set;
  wire wr_loop = WR_STB & hit_loop;
  wire wr_mon = WR_STB & hit_mon;
  wire wr_on = WR_STB & hit_on;
  wire wr_off = WR_STB & hit_off;
  wire wr_vexp = WR_STB & hit_vexp;
  wire wr_ro = WR_STB & hit_cap;
  wire wr_unmapped = WR_STB & ~hit_any;
  wire rd_unmapped = RD_STB & ~hit_any;
  wire bad_cmd = wr_ro | wr_unmapped | rd_unmapped;

  // ------------------------------------------------------------
  // Write fields
  // ------------------------------------------------------------
  // Only writable slices are taken; read-only bits of a write fall away here
  wire [2:0] wd_fmt_exp = WR_DATA[`VFR_F_FMT_EXP];
  wire [11:0] wd_set_mant = WR_DATA[`VFR_F_SET_MANT];
  wire [2:0] wd_scl_exp = WR_DATA[`VFR_F_SCL_EXP];
  wire [9:0] wd_scl_mant = WR_DATA[`VFR_F_SCL_MANT];
  wire [10:0] wd_vin_mant = WR_DATA[`VFR_F_VIN_MANT];
  wire [2:0] wd_vin_exp = WR_DATA[`VFR_F_VINEXP_SRC];

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [2:0] fmt_exp_q;
  logic [11:0] set_mant_q;
  logic [2:0] loop_exp_q;
  logic [9:0] loop_mant_q;
  logic [2:0] mon_exp_q;
  logic [9:0] mon_mant_q;
  logic [10:0] on_mant_q;
  logic [10:0] off_mant_q;
  logic [2:0] vin_exp_q;

  // Only writable fields are captured; everything else is rebuilt on read
  // ------------------------------------------------------------
  // Output voltage format and setpoint
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      fmt_exp_q <= `VFR_RST_EXP3;
    end else if (wr_fmt) begin
      fmt_exp_q <= wd_fmt_exp;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      set_mant_q <= `VFR_RST_SET_MANT;
    end else if (wr_set) begin
      set_mant_q <= wd_set_mant;
    end
  end

  // ------------------------------------------------------------
  // Scale factors
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      loop_exp_q <= `VFR_RST_EXP3;
      loop_mant_q <= `VFR_RST_SCL_MANT;
    end else if (wr_loop) begin
      loop_exp_q <= wd_scl_exp;
      loop_mant_q <= wd_scl_mant;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mon_exp_q <= `VFR_RST_EXP3;
      mon_mant_q <= `VFR_RST_SCL_MANT;
    end else if (wr_mon) begin
      mon_exp_q <= wd_scl_exp;
      mon_mant_q <= wd_scl_mant;
    end
  end

  // ------------------------------------------------------------
  // Input thresholds and input exponent
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      on_mant_q <= `VFR_RST_VIN_MANT;
    end else if (wr_on) begin
      on_mant_q <= wd_vin_mant;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      off_mant_q <= `VFR_RST_VIN_MANT;
    end else if (wr_off) begin
      off_mant_q <= wd_vin_mant;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      vin_exp_q <= `VFR_RST_EXP3;
    end else if (wr_vexp) begin
      vin_exp_q <= wd_vin_exp;
    end
  end

  // ------------------------------------------------------------
  // Read view of each register
  // ------------------------------------------------------------
  // Sign-extended so the 5-bit field keeps the value of the 3-bit exponent
  wire [4:0] vin_exp5 = 5'($signed(vin_exp_q));

  logic [15:0] rv_cap;
  logic [15:0] rv_fmt;
  logic [15:0] rv_set;
  logic [15:0] rv_loop;
  logic [15:0] rv_mon;
  logic [15:0] rv_on;
  logic [15:0] rv_off;
  logic [15:0] rv_vexp;

  // Fixed capability byte and output voltage registers
  always_comb begin
    rv_cap = `VFR_ZERO16;
    rv_cap[`VFR_F_CAP_BYTE] = `VFR_CAP_VALUE;
    rv_fmt = `VFR_ZERO16;
    rv_fmt[`VFR_F_FMT_MODE] = `VFR_MODE_LINEAR;
    rv_fmt[`VFR_F_FMT_EXP] = fmt_exp_q;
    rv_set = `VFR_ZERO16;
    rv_set[`VFR_F_SET_MANT] = set_mant_q;
  end

  // Reserved bits of both scale registers read zero
  always_comb begin
    rv_loop = `VFR_ZERO16;
    rv_loop[`VFR_F_SCL_EXP] = loop_exp_q;
    rv_loop[`VFR_F_SCL_MANT] = loop_mant_q;
    rv_mon = `VFR_ZERO16;
    rv_mon[`VFR_F_SCL_EXP] = mon_exp_q;
    rv_mon[`VFR_F_SCL_MANT] = mon_mant_q;
  end

  // Thresholds show the shared input exponent, never a stored copy
  always_comb begin
    rv_on = `VFR_ZERO16;
    rv_on[`VFR_F_VIN_EXP] = vin_exp5;
    rv_on[`VFR_F_VIN_MANT] = on_mant_q;
    rv_off = `VFR_ZERO16;
    rv_off[`VFR_F_VIN_EXP] = vin_exp5;
    rv_off[`VFR_F_VIN_MANT] = off_mant_q;
    rv_vexp = `VFR_ZERO16;
    rv_vexp[`VFR_F_VINEXP_SRC] = vin_exp_q;
  end

  wire [15:0] rd_sel =
    hit_cap ? rv_cap :
    hit_fmt ? rv_fmt :
    hit_set ? rv_set :
    hit_loop ? rv_loop :
    hit_mon ? rv_mon :
    hit_on ? rv_on :
    hit_off ? rv_off :
    hit_vexp ? rv_vexp : `VFR_ZERO16;

  // ------------------------------------------------------------
  // Answer path
  // ------------------------------------------------------------
  logic [15:0] rd_data_q;
  logic rd_ack_q;
  logic cmd_err_q;

  // Read data holds until the next read so a slow engine can shift it out
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rd_data_q <= `VFR_ZERO16;
    end else if (RD_STB) begin
      rd_data_q <= rd_sel;
    end
  end

  // Acknowledge and error are one-cycle pulses
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rd_ack_q <= 1'b0;
    end else begin
      rd_ack_q <= RD_STB;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cmd_err_q <= 1'b0;
    end else begin
      cmd_err_q <= bad_cmd;
    end
  end

  assign RD_DATA = rd_data_q;
  assign RD_ACK = rd_ack_q;
  assign CMD_ERR = cmd_err_q;

  // ------------------------------------------------------------
  // Targets handed to the control loops
  // ------------------------------------------------------------
  assign VOUT_TARGET = '{exp: fmt_exp_q, mant: set_mant_q};
  assign LOOP_SCALE = '{exp: loop_exp_q, mant: loop_mant_q};
  assign MONITOR_SCALE_VALUE = '{exp: mon_exp_q, mant: mon_mant_q};
  assign VIN_EXP = vin_exp_q;

  // ------------------------------------------------------------
  // Start and stop of power conversion
  // ------------------------------------------------------------
  // Both thresholds share one exponent, so mantissas compare directly.
  // A stop threshold set above the start threshold makes the converter
  // start and stop on alternate cycles; software must keep them apart.
  vfr_conv_t conv_q;
  vfr_conv_t conv_d;

  wire vin_reached_on = (VIN_MEAS >= on_mant_q);
  wire vin_fell_off = (VIN_MEAS <= off_mant_q);

  always_comb begin
    conv_d = conv_q;
    unique case (conv_q)
      VFR_HALT: begin
        if (vin_reached_on) begin
          conv_d = VFR_RUN;
        end
      end
      VFR_RUN: begin
        if (vin_fell_off) begin
          conv_d = VFR_HALT;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      conv_q <= VFR_HALT;
    end else begin
      conv_q <= conv_d;
    end
  end

  assign CONVERT_EN = (conv_q == VFR_RUN);

endmodule : vfr_voltage_format_regs

//--- vfr_voltage_format_regs_chk.sv
// Port checker for the voltage format register bank.
// Assumes one clock domain and the one-cycle read answer of the bank.
module vfr_voltage_format_regs_chk
  import vfr_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [15:0] CMD,
  input wire logic WR_STB,
  input wire logic [15:0] WR_DATA,
  input wire logic RD_STB,
  input wire logic [15:0] RD_DATA,
  input wire logic RD_ACK,
  input wire logic CMD_ERR,
  input wire vfr_setpoint_t VOUT_TARGET,
  input wire vfr_scale_t LOOP_SCALE,
  input wire vfr_scale_t MONITOR_SCALE_VALUE,
  input wire logic [2:0] VIN_EXP
);
  logic [15:0] wd_q;
  logic [2:0] ve_q;
  always_ff @(posedge CLK) begin
    wd_q <= WR_DATA;
    ve_q <= VIN_EXP;
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  a_cap_fixed: assert property (RD_STB && CMD == 16'h0019 |=> RD_ACK && RD_DATA == 16'h0020)
    else $error("capability read wrong");
  a_fmt_mode: assert property (RD_STB && CMD == 16'h0020 |=> RD_DATA[15:3] == 13'h0000)
    else $error("format upper bits not zero");
  a_fmt_exp: assert property (WR_STB && CMD == 16'h0020 |=> VOUT_TARGET.exp == wd_q[2:0])
    else $error("output exponent not stored");
  a_set_upper: assert property (RD_STB && CMD == 16'h0021 |=> RD_DATA[15:12] == 4'h0)
    else $error("setpoint upper bits not zero");
  a_set_mant: assert property (WR_STB && CMD == 16'h0021 |=> VOUT_TARGET.mant == wd_q[11:0])
    else $error("setpoint not stored");
  a_loop_write: assert property (WR_STB && CMD == 16'h0029 |=> LOOP_SCALE == {wd_q[13:11], wd_q[9:0]})
    else $error("loop scale not stored");
  a_mon_write: assert property (WR_STB && CMD == 16'h002a |=> MONITOR_SCALE_VALUE == {wd_q[13:11], wd_q[9:0]})
    else $error("monitor scale not stored");
  a_vin_exp: assert property (RD_STB && CMD inside {16'h0035, 16'h0036} |=> RD_DATA[15:11] == {{2{ve_q[2]}}, ve_q})
    else $error("threshold exponent wrong");
  a_cap_refuse: assert property (WR_STB && CMD == 16'h0019 |=> CMD_ERR)
    else $error("capability write not refused");
endmodule : vfr_voltage_format_regs_chk

bind vfr_voltage_format_regs vfr_voltage_format_regs_chk u_chk(.CLK(CLK), .RSTN(RSTN), .CMD(CMD), .WR_STB(WR_STB),
  .WR_DATA(WR_DATA), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .RD_ACK(RD_ACK), .CMD_ERR(CMD_ERR),
  .VOUT_TARGET(VOUT_TARGET), .LOOP_SCALE(LOOP_SCALE), .MONITOR_SCALE_VALUE(MONITOR_SCALE_VALUE), .VIN_EXP(VIN_EXP));

//--- vfr_host_model.sv
// Host side model: issues one-cycle register requests.
// Assumes the bank answers reads exactly one edge after the request.
module vfr_host_model (
  input wire logic clk,
  output logic [15:0] cmd,
  output logic wr_stb,
  output logic [15:0] wr_data,
  output logic rd_stb,
  input wire logic [15:0] rd_data,
  input wire logic rd_ack,
  input wire logic cmd_err
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd = 16'h0000;
    wr_stb = 1'b0;
    wr_data = 16'h0000;
    rd_stb = 1'b0;
  end
  task automatic acc(input logic w, input logic [15:0] c, input logic [15:0] d, output logic [15:0] q,
    output logic e);
    @(posedge clk);
    cmd <= c;
    wr_data <= d;
    wr_stb <= w;
    rd_stb <= !w;
    @(posedge clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    // Scramble released lines so stale values are never relied on
    cmd <= ~c;
    wr_data <= ~d;
    #1;
    q = (rd_ack || w) ? rd_data : 16'hxxxx;
    e = cmd_err;
  endtask : acc
endmodule : vfr_host_model

//--- voltage_format_register_bank_bench.sv
// Self-checking bench for the voltage format register bank.
// Assumes the host model drives requests; expectations come from a local model.
module voltage_format_register_bank_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic [10:0] vin = 11'h000;
  logic [15:0] cmd, wd, rd, q;
  logic ws, rs, ack, err, conv, e;
  int n_errors = 0;
  int n_checks = 0;
  logic [31:0] rng = 32'h8923;
  logic [2:0] fmt = 3'h0, le = 3'h0, me = 3'h0, ve = 3'h0;
  logic [11:0] sp = 12'h000;
  logic [9:0] lm = 10'h000, mm = 10'h000;
  logic [10:0] vs = 11'h000, vp = 11'h000;
  logic [15:0] tbl [9] = '{16'h0019, 16'h0020, 16'h0021, 16'h0029, 16'h002a, 16'h0035, 16'h0036, 16'hfe39, 16'h0099};
  always #25 CLK = ~CLK;
  vfr_voltage_format_regs u_vfr_voltage_format_regs(.CLK(CLK), .RSTN(RSTN), .CMD(cmd), .WR_STB(ws), .WR_DATA(wd),
    .RD_STB(rs), .RD_DATA(rd), .RD_ACK(ack), .CMD_ERR(err), .VIN_MEAS(vin), .VOUT_TARGET(), .LOOP_SCALE(),
    .MONITOR_SCALE_VALUE(), .VIN_EXP(), .CONVERT_EN(conv));
  vfr_host_model u_vfr_host_model(.clk(CLK), .cmd(cmd), .wr_stb(ws), .wr_data(wd), .rd_stb(rs), .rd_data(rd),
    .rd_ack(ack), .cmd_err(err));
  function automatic logic [15:0] exp_rd(input logic [15:0] c);
    case (c)
      16'h0019: return 16'h0020;
      16'h0020: return {13'h0000, fmt};
      16'h0021: return {4'h0, sp};
      16'h0029: return {2'b00, le, 1'b0, lm};
      16'h002a: return {2'b00, me, 1'b0, mm};
      16'h0035: return {{2{ve[2]}}, ve, vs};
      16'h0036: return {{2{ve[2]}}, ve, vp};
      16'hfe39: return {10'h000, ve, 3'h0};
      default: return 16'h0000;
    endcase
  endfunction : exp_rd
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] t;
    t = s;
    t ^= t << 13;
    t ^= t >> 17;
    t ^= t << 5;
    return t;
  endfunction : xorshift
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic vt(input logic [10:0] v, input logic x);
    @(posedge CLK);
    vin <= v;
    repeat (3) @(posedge CLK);
    #1;
    chk("convert_en", {15'h0000, conv}, {15'h0000, x});
  endtask : vt
  task automatic finish_test;
    if (n_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  initial begin
    #100000;
    n_errors++;
    finish_test();
  end
  // ----------------------------------------
  // Random write then read-back of every code
  // ----------------------------------------
  initial begin : main
    logic [15:0] c;
    logic [15:0] d;
    repeat (8) @(posedge CLK);
    RSTN <= 1'b1;
    for (int i = 0; i < 80; i++) begin
      rng = xorshift(rng);
      c = tbl[rng % 9];
      d = rng[31:16];
      u_vfr_host_model.acc(1'b1, c, d, q, e);
      chk("write_refused", {15'h0000, e}, {15'h0000, c inside {16'h0019, 16'h0099}});
      case (c)
        16'h0020: fmt = d[2:0];
        16'h0021: sp = d[11:0];
        16'h0029: {le, lm} = {d[13:11], d[9:0]};
        16'h002a: {me, mm} = {d[13:11], d[9:0]};
        16'h0035: vs = d[10:0];
        16'h0036: vp = d[10:0];
        16'hfe39: ve = d[5:3];
        default: ;
      endcase
      u_vfr_host_model.acc(1'b0, c, 16'h0000, q, e);
      chk("read_back", q, exp_rd(c));
      chk("read_refused", {15'h0000, e}, {15'h0000, c == 16'h0099});
    end
    // ----------------------------------------
    // Start and stop thresholds with hysteresis
    // ----------------------------------------
    u_vfr_host_model.acc(1'b1, 16'h0036, 16'h0032, q, e);
    u_vfr_host_model.acc(1'b1, 16'h0035, 16'h0064, q, e);
    vt(11'd80, 1'b0);
    vt(11'd100, 1'b1);
    vt(11'd60, 1'b1);
    vt(11'd50, 1'b0);
    vt(11'd99, 1'b0);
    finish_test();
  end
endmodule : voltage_format_register_bank_bench
